// ===== ts_cfg.svh
// register offsets, reset values and timing counts of the temperature alarm block
`ifndef TS_CFG_SVH
`define TS_CFG_SVH

// ==================================================
// register pointer values
`define TS_PTR_TEMP 2'h0
`define TS_PTR_CONF 2'h1
`define TS_PTR_HYS 2'h2
`define TS_PTR_OS 2'h3

// ==================================================
// reset values
`define TS_TEMP_RST 16'h0000
`define TS_CFG_RST 8'h00
`define TS_HYS_RST 16'h4B00
`define TS_OS_RST 16'h5000
`define TS_PTR_RST 2'h0

// ==================================================
// configuration field positions
`define TS_CFG_SD_BIT 0
`define TS_CFG_MODE_BIT 1
`define TS_CFG_POL_BIT 2
`define TS_CFG_FQ_LO 3
`define TS_CFG_FQ_HI 4

// ==================================================
// bus address and timing
`define TS_ADDR_HI 4'h9
`define TS_SCL_MAX_KHZ 400
`define TS_CLK_MHZ 200
`define TS_CONV_TIME_US 45000
`define TS_CONV_CYCLES (`TS_CONV_TIME_US * `TS_CLK_MHZ)

`endif

// ===== ts_pkg.sv
// types shared by the temperature alarm block
package ts_pkg;

    // ==================================================
    // configuration byte, bit 0 at the bottom
    typedef struct packed {
        logic [2:0] spare;
        logic fault_count_hi;
        logic fault_count_lo;
        logic alarm_polarity;
        logic int_mode;
        logic shutdown;
    } cfg_t;

    // ==================================================
    // serial slave states
    typedef enum logic [5:0] {
        ST_IDLE = 6'b000001,
        ST_ADDR = 6'b000010,
        ST_ACK = 6'b000100,
        ST_WR = 6'b001000,
        ST_RD = 6'b010000,
        ST_RACK = 6'b100000
    } bus_state_t;

endpackage

// ===== temp_sensor_thermal_alarm.sv
// temperature readout, threshold alarm and two-wire register slave
`include "ts_cfg.svh"

// Contract
// - results are 9-bit codes, half a degree per step
// - bus sampling keeps up with a master clocking up to 400 kHz
// - three address select pins give the low slave address bits
// - alarm runs in comparator or interrupt mode per configuration
// - conversions start after reset with no bus command
// - each result is compared against overlimit and hysteresis thresholds, except in interrupt mode while the alarm is set
// - result is stored as a 16-bit two's complement word
// - temperature reads never disturb the running conversion
// - code sits in bits 15..7, bits 6..0 read zero
// - alarm updates after each comparison using result and mode
// - two fault bits set the consecutive-conversion queue depth
// - polarity bit picks the alarm active level, low after reset
// - interrupt mode fires an event when over the overlimit
// - comparator mode acts as a thermostat with hysteresis
// - threshold registers keep every written bit
// - reset defaults let the alarm work with no bus traffic
// - results are in degrees Celsius only
// - every register is reachable over the two-wire bus
// - fault field 00,01,10,11 means 1,2,4,6 faults, default 00
// - comparator alarm holds until a result drops below hysteresis
// - interrupt alarm clears on any read, re-arms after low results
// - pointer holds between transactions and resets to zero
module temp_sensor_thermal_alarm #(
    parameter int unsigned CONV_CYCLES = `TS_CONV_CYCLES,
    parameter logic [3:0] ADDR_HI = `TS_ADDR_HI
) (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_n_i,
    // converter code, same clock domain
    input wire logic [8:0] adc_code_i,
    // two-wire bus
    input wire logic scl_i,
    input wire logic sda_in_i,
    output logic sda_out_o,
    output logic sda_oe_o,
    // address straps
    input wire logic addr_sel_0_i,
    input wire logic addr_sel_1_i,
    input wire logic addr_sel_2_i,
    // alarm pin
    output logic alarm_out_o,
    output logic alarm_oe_o
);

    // ==================================================
    // pin synchronisers
    logic [1:0] scl_sy, sda_sy;
    logic [2:0] asel_m, asel_s;
    logic scl_d, sda_d;

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            scl_sy <= 2'h3;
            sda_sy <= 2'h3;
            asel_m <= 3'h0;
            asel_s <= 3'h0;
            scl_d <= 1'b1;
            sda_d <= 1'b1;
        end else begin
            // 5 ns sampling is far finer than any 400 kHz bit
            scl_sy <= {scl_sy[0], scl_i};
            sda_sy <= {sda_sy[0], sda_in_i};
            asel_m <= {addr_sel_2_i, addr_sel_1_i, addr_sel_0_i};
            asel_s <= asel_m;
            scl_d <= scl_sy[1];
            sda_d <= sda_sy[1];
        end
    end

    wire scl_s = scl_sy[1];
    wire sda_s = sda_sy[1];
    wire scl_rise = scl_s & ~scl_d;
    wire scl_fall = ~scl_s & scl_d;
    wire bus_start = scl_s & scl_d & sda_d & ~sda_s;
    wire bus_stop = scl_s & scl_d & ~sda_d & sda_s;

    // ==================================================
    // register file
    ts_pkg::cfg_t cfg_reg;
    ts_pkg::bus_state_t st_reg;
    logic [1:0] ptr_reg;
    logic [15:0] temp_reg, hys_reg, os_reg;
    logic [7:0] shift_reg, wr_hi_reg;
    logic [3:0] bit_cnt_reg;
    logic [1:0] byte_idx_reg;
    logic rw_reg, rd_hi_reg, ack_ok_reg, sda_oe_reg;
    logic rd_evt_reg, ptr_wr_reg;

    wire [15:0] cfg_word = {cfg_reg, cfg_reg};
    wire [15:0] rd_word = (ptr_reg == `TS_PTR_TEMP) ? temp_reg :
                          (ptr_reg == `TS_PTR_CONF) ? cfg_word :
                          (ptr_reg == `TS_PTR_HYS) ? hys_reg : os_reg;
    wire [7:0] tx_byte = rd_hi_reg ? rd_word[15:8] : rd_word[7:0];
    wire addr_match = (shift_reg[7:1] == {ADDR_HI, asel_s});
    wire byte_done = scl_fall & (bit_cnt_reg == 4'h8);
    wire [3:0] bit_inc = 4'(bit_cnt_reg + 4'h1);
    wire [1:0] idx_inc = (byte_idx_reg == 2'h3) ? 2'h3 : 2'(byte_idx_reg + 2'h1);
    wire ptr_ok = (shift_reg[7:2] == 6'h00);

    // ==================================================
    // serial slave
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            st_reg <= ts_pkg::ST_IDLE;
            ptr_reg <= `TS_PTR_RST;
            cfg_reg <= ts_pkg::cfg_t'(`TS_CFG_RST);
            hys_reg <= `TS_HYS_RST;
            os_reg <= `TS_OS_RST;
            shift_reg <= 8'h00;
            wr_hi_reg <= 8'h00;
            bit_cnt_reg <= 4'h0;
            byte_idx_reg <= 2'h0;
            rw_reg <= 1'b0;
            rd_hi_reg <= 1'b1;
            ack_ok_reg <= 1'b0;
            sda_oe_reg <= 1'b0;
            rd_evt_reg <= 1'b0;
            ptr_wr_reg <= 1'b0;
        end else begin
            rd_evt_reg <= 1'b0;
            ptr_wr_reg <= 1'b0;
            if (bus_start) begin
                st_reg <= ts_pkg::ST_ADDR;
                bit_cnt_reg <= 4'h0;
                byte_idx_reg <= 2'h0;
                sda_oe_reg <= 1'b0;
            end else if (bus_stop) begin
                st_reg <= ts_pkg::ST_IDLE;
                sda_oe_reg <= 1'b0;
            end else begin
                case (st_reg)
                    ts_pkg::ST_ADDR, ts_pkg::ST_WR: begin
                        if (scl_rise) begin
                            shift_reg <= {shift_reg[6:0], sda_s};
                            bit_cnt_reg <= bit_inc;
                        end else if (byte_done) begin
                            bit_cnt_reg <= 4'h0;
                            if (st_reg == ts_pkg::ST_ADDR) begin
                                if (addr_match) begin
                                    rw_reg <= shift_reg[0];
                                    rd_hi_reg <= 1'b1;
                                    sda_oe_reg <= 1'b1;
                                    st_reg <= ts_pkg::ST_ACK;
                                end else begin
                                    st_reg <= ts_pkg::ST_IDLE;
                                end
                            end else begin
                                byte_idx_reg <= idx_inc;
                                sda_oe_reg <= 1'b1;
                                st_reg <= ts_pkg::ST_ACK;
                                if (byte_idx_reg == 2'h0) begin
                                    if (ptr_ok) begin
                                        ptr_reg <= shift_reg[1:0];
                                        ptr_wr_reg <= 1'b1;
                                    end else begin
                                        sda_oe_reg <= 1'b0;
                                        st_reg <= ts_pkg::ST_IDLE;
                                    end
                                end else if (byte_idx_reg == 2'h1) begin
                                    if (ptr_reg == `TS_PTR_CONF) begin
                                        cfg_reg <= ts_pkg::cfg_t'(shift_reg);
                                    end else begin
                                        wr_hi_reg <= shift_reg;
                                    end
                                end else if (byte_idx_reg == 2'h2) begin
                                    // all 16 bits kept so the pair can serve as storage
                                    if (ptr_reg == `TS_PTR_HYS) begin
                                        hys_reg <= {wr_hi_reg, shift_reg};
                                    end else if (ptr_reg == `TS_PTR_OS) begin
                                        os_reg <= {wr_hi_reg, shift_reg};
                                    end
                                end
                            end
                        end
                    end
                    ts_pkg::ST_ACK: begin
                        if (scl_fall) begin
                            if (rw_reg) begin
                                shift_reg <= tx_byte;
                                sda_oe_reg <= ~tx_byte[7];
                                rd_hi_reg <= ~rd_hi_reg;
                                rd_evt_reg <= 1'b1;
                                bit_cnt_reg <= 4'h0;
                                st_reg <= ts_pkg::ST_RD;
                            end else begin
                                sda_oe_reg <= 1'b0;
                                st_reg <= ts_pkg::ST_WR;
                            end
                        end
                    end
                    ts_pkg::ST_RD: begin
                        if (scl_fall) begin
                            if (bit_cnt_reg == 4'h7) begin
                                sda_oe_reg <= 1'b0;
                                st_reg <= ts_pkg::ST_RACK;
                            end else begin
                                bit_cnt_reg <= bit_inc;
                                shift_reg <= {shift_reg[6:0], 1'b0};
                                sda_oe_reg <= ~shift_reg[6];
                            end
                        end
                    end
                    ts_pkg::ST_RACK: begin
                        if (scl_rise) begin
                            ack_ok_reg <= ~sda_s;
                        end else if (scl_fall) begin
                            if (ack_ok_reg) begin
                                shift_reg <= tx_byte;
                                sda_oe_reg <= ~tx_byte[7];
                                rd_hi_reg <= ~rd_hi_reg;
                                bit_cnt_reg <= 4'h0;
                                st_reg <= ts_pkg::ST_RD;
                            end else begin
                                st_reg <= ts_pkg::ST_IDLE;
                            end
                        end
                    end
                    default: begin
                        st_reg <= ts_pkg::ST_IDLE;
                    end
                endcase
            end
        end
    end

    // ==================================================
    // conversion sequencer
    logic [31:0] conv_cnt_reg;
    logic conv_run_reg;
    wire conv_done = conv_run_reg & (conv_cnt_reg == CONV_CYCLES - 1);

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            conv_cnt_reg <= 32'h0;
            conv_run_reg <= 1'b1;
            temp_reg <= `TS_TEMP_RST;
        end else begin
            if (conv_done) begin
                // Celsius code stored as is, low seven bits zero
                temp_reg <= {adc_code_i, 7'h00};
                conv_cnt_reg <= 32'h0;
                conv_run_reg <= ~cfg_reg.shutdown;
            end else if (conv_run_reg) begin
                conv_cnt_reg <= conv_cnt_reg + 32'h1;
            end else if (!cfg_reg.shutdown) begin
                conv_run_reg <= 1'b1;
            end
        end
    end

    // ==================================================
    // alarm logic
    function automatic logic [2:0] fault_need(input logic [1:0] f);
        case (f)
            2'b00: fault_need = 3'h1;
            2'b01: fault_need = 3'h2;
            2'b10: fault_need = 3'h4;
            default: fault_need = 3'h6;
        endcase
    endfunction

    logic alarm_act_reg, look_low_reg, alarm_oe_reg, sda_zero_reg;
    logic [2:0] fault_cnt_reg;
    logic act_next, look_next;
    logic [2:0] cnt_next;

    wire above_os = $signed(adc_code_i) > $signed(os_reg[15:7]);
    wire below_hys = $signed(adc_code_i) < $signed(hys_reg[15:7]);
    wire [2:0] need = fault_need({cfg_reg.fault_count_hi, cfg_reg.fault_count_lo});
    wire [2:0] cnt_inc = 3'(fault_cnt_reg + 3'h1);
    wire qual_int = look_low_reg ? below_hys : above_os;

    always_comb begin
        act_next = alarm_act_reg;
        look_next = look_low_reg;
        cnt_next = fault_cnt_reg;
        if (!cfg_reg.int_mode) begin
            if (conv_done) begin
                if (alarm_act_reg) begin
                    if (below_hys) begin
                        act_next = 1'b0;
                    end
                end else if (above_os) begin
                    cnt_next = (cnt_inc >= need) ? 3'h0 : cnt_inc;
                    act_next = (cnt_inc >= need);
                end else begin
                    cnt_next = 3'h0;
                end
            end
            look_next = 1'b0;
        end else begin
            // a read and a trip in one cycle: the trip wins
            if (alarm_act_reg && (rd_evt_reg || cfg_reg.shutdown)) begin
                act_next = 1'b0;
            end
            if (conv_done && !alarm_act_reg) begin
                if (qual_int) begin
                    cnt_next = (cnt_inc >= need) ? 3'h0 : cnt_inc;
                    if (cnt_inc >= need) begin
                        act_next = 1'b1;
                        look_next = ~look_low_reg;
                    end
                end else begin
                    cnt_next = 3'h0;
                end
            end
        end
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            alarm_act_reg <= 1'b0;
            look_low_reg <= 1'b0;
            fault_cnt_reg <= 3'h0;
            alarm_oe_reg <= 1'b0;
            sda_zero_reg <= 1'b0;
        end else begin
            alarm_act_reg <= act_next;
            look_low_reg <= look_next;
            fault_cnt_reg <= cnt_next;
            // pin level comes from the pull-up, so low is the only driven level
            alarm_oe_reg <= alarm_act_reg ^ cfg_reg.alarm_polarity;
            sda_zero_reg <= 1'b0;
        end
    end

    assign sda_out_o = sda_zero_reg;
    assign sda_oe_o = sda_oe_reg;
    assign alarm_out_o = sda_zero_reg;
    assign alarm_oe_o = alarm_oe_reg;

    // ==================================================
    // checks
    a_temp_capture: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        conv_done |=> temp_reg == {$past(adc_code_i), 7'h00})
        else $error("temperature word not captured");
    a_conv_repeat: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        conv_done && !cfg_reg.shutdown |=> conv_run_reg && conv_cnt_reg == 32'h0 ##1 conv_cnt_reg == 32'h1)
        else $error("conversion did not restart");
    a_pin_level: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        ##1 alarm_oe_o == ($past(alarm_act_reg) ^ $past(cfg_reg.alarm_polarity)))
        else $error("alarm pin level wrong");
    a_trip_cause: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        $rose(alarm_act_reg) |-> $past(conv_done) && $past(cnt_inc >= need))
        else $error("alarm tripped without full queue");
    a_cmp_release: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        !cfg_reg.int_mode && alarm_act_reg && conv_done && below_hys |=> !alarm_act_reg)
        else $error("comparator alarm not released");
    a_int_read_clear: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        cfg_reg.int_mode && alarm_act_reg && rd_evt_reg && !conv_done |=> !alarm_act_reg)
        else $error("interrupt alarm not cleared by read");
    a_ptr_hold: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        !ptr_wr_reg |-> ptr_reg == $past(ptr_reg))
        else $error("pointer changed without write");
    a_sync_delay: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        ##3 scl_d == $past(scl_i, 3))
        else $error("scl sampling delay wrong");
    a_cmp_hold: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        !cfg_reg.int_mode && alarm_act_reg && !conv_done |=> alarm_act_reg)
        else $error("comparator alarm dropped between results");

endmodule

// ===== i2c_master_model.sv
// two-wire bus master model: open-drain data, clock idles high between frames
module i2c_master_model (
    // reference clock, used only to keep bus edges off its rising edge
    input wire logic clk_i,
    // bus wires
    input wire logic sda_i,
    output logic scl_o,
    output logic sda_oe_o
);
    timeunit 1ns;
    timeprecision 10ps;
    // quarter of the 125 ns bus period
    localparam realtime QTR = 31.25;

    initial begin
        scl_o = 1'b1;
        sda_oe_o = 1'b0;
    end

    // ======================================
    // bus conditions
    task automatic start();
        @(posedge clk_i);
        #1;
        sda_oe_o = 1'b0;
        #QTR scl_o = 1'b1;
        #QTR sda_oe_o = 1'b1;
        #QTR scl_o = 1'b0;
        #QTR;
    endtask

    task automatic stop();
        sda_oe_o = 1'b1;
        #QTR scl_o = 1'b1;
        #QTR sda_oe_o = 1'b0;
        #(2 * QTR);
    endtask

    // ======================================
    // bits and bytes
    task automatic bit_io(input logic b, output logic r);
        sda_oe_o = ~b;
        #QTR scl_o = 1'b1;
        #QTR r = sda_i;
        #QTR scl_o = 1'b0;
        #QTR;
    endtask

    // a read sends d = FF so the slave owns the line; last is the ack bit sent
    task automatic xfer(input logic [7:0] d, input logic last, output logic [7:0] q, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            bit_io(d[i], r);
            q[i] = r;
        end
        bit_io(last, r);
        ack = ~r;
    endtask
endmodule

// ===== temp_sensor_thermal_alarm_tb.sv
// self-checking bench for the temperature alarm block
module temp_sensor_thermal_alarm_tb;
    timeunit 1ns;
    timeprecision 10ps;
    // short conversion so many results fit one run
    localparam int C = 400;
    localparam logic [6:0] DEV = {4'h9, 3'h5};
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic [8:0] adc = 9'h032;
    logic [2:0] strap = 3'h5;
    logic scl;
    logic mst_oe;
    logic sda_out;
    logic sda_oe;
    logic alarm_out;
    logic alarm_oe;
    // pull-up unless someone pulls low
    wire logic sda_w = ~(sda_oe | mst_oe);
    int fails = 0;
    int n_compared = 0;

    always #2.5 clk = ~clk;

    temp_sensor_thermal_alarm #(.CONV_CYCLES(C), .ADDR_HI(4'h9)) temp_sensor_thermal_alarm_inst (
        .clk_i(clk), .rst_n_i(rst_n), .adc_code_i(adc), .scl_i(scl), .sda_in_i(sda_w),
        .sda_out_o(sda_out), .sda_oe_o(sda_oe), .addr_sel_0_i(strap[0]), .addr_sel_1_i(strap[1]),
        .addr_sel_2_i(strap[2]), .alarm_out_o(alarm_out), .alarm_oe_o(alarm_oe));

    i2c_master_model i2c_master_model_inst (.clk_i(clk), .sda_i(sda_w), .scl_o(scl), .sda_oe_o(mst_oe));

    // ======================================
    // helpers
    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        n_compared++;
        if (seen !== exp) begin
            fails++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic bx(input logic [7:0] d, input logic last, output logic [7:0] q, output logic a);
        i2c_master_model_inst.xfer(d, last, q, a);
    endtask

    task automatic addr(input logic rd);
        logic [7:0] q;
        logic a;
        i2c_master_model_inst.start();
        bx({DEV, rd}, 1'b1, q, a);
        check("address ack", {15'h0, a}, 16'h1);
    endtask

    task automatic wr(input logic [1:0] p, input logic [15:0] v, input int n);
        logic [7:0] q;
        logic a;
        addr(1'b0);
        bx({6'h00, p}, 1'b1, q, a);
        check("pointer ack", {15'h0, a}, 16'h1);
        if (n == 2) bx(v[15:8], 1'b1, q, a);
        if (n > 0) bx(v[7:0], 1'b1, q, a);
        i2c_master_model_inst.stop();
    endtask

    task automatic rd_cur(input int n, output logic [15:0] v);
        logic [7:0] q;
        logic a;
        addr(1'b1);
        bx(8'hFF, n == 1, q, a);
        v = {8'h00, q};
        if (n == 2) begin
            bx(8'hFF, 1'b1, q, a);
            v = {v[7:0], q};
        end
        i2c_master_model_inst.stop();
    endtask

    task automatic rdchk(input logic [1:0] p, input int n, input logic [15:0] e, input string what);
        logic [15:0] v;
        wr(p, 16'h0000, 0);
        rd_cur(n, v);
        check(what, v, e);
    endtask

    task automatic code(input logic [8:0] c);
        @(negedge clk);
        adc = c;
    endtask

    task automatic wait_oe(input logic want, input int lo, input int hi, input string what);
        int t;
        t = 0;
        while (alarm_oe !== want && t <= hi) begin
            @(negedge clk);
            t++;
        end
        check(what, {15'h0, t >= lo && t <= hi}, 16'h1);
    endtask

    // every cycle of the span must show the level
    task automatic hold_oe(input logic want, input int n, input string what);
        int bad;
        bad = 0;
        repeat (n) begin
            @(negedge clk);
            if (alarm_oe !== want) bad++;
        end
        check(what, 16'(bad), 16'h0);
    endtask

    // ======================================
    // scenarios
    task automatic t_reset();
        logic [15:0] v;
        repeat (C + 10) @(negedge clk);
        rd_cur(2, v);
        check("first result", v, 16'h1900);
        rdchk(2'h1, 1, 16'h0000, "config reset");
        rdchk(2'h2, 2, 16'h4B00, "hysteresis reset");
        rdchk(2'h3, 2, 16'h5000, "overlimit reset");
        rd_cur(2, v);
        check("pointer kept", v, 16'h5000);
        check("idle alarm", {15'h0, alarm_oe}, 16'h0);
    endtask

    task automatic t_format();
        logic [15:0] v;
        code(9'h1CE);
        repeat (C + 10) @(negedge clk);
        rdchk(2'h0, 2, 16'hE700, "negative result");
        code(9'h0FA);
        repeat (C + 10) @(negedge clk);
        rd_cur(2, v);
        check("next result", v, 16'h7D00);
        code(9'h032);
        repeat (C + 10) @(negedge clk);
    endtask

    task automatic t_regs();
        logic [15:0] v;
        logic [7:0] q;
        logic a;
        wr(2'h3, 16'hA5C3, 2);
        rdchk(2'h3, 2, 16'hA5C3, "overlimit storage");
        wr(2'h2, 16'h5A3C, 2);
        rdchk(2'h2, 2, 16'h5A3C, "hysteresis storage");
        wr(2'h0, 16'hFFFF, 2);
        rdchk(2'h0, 2, 16'h1900, "temperature write");
        addr(1'b0);
        // low bits 11, so a wrongly taken pointer would read back the overlimit word
        bx(8'h07, 1'b1, q, a);
        check("bad pointer", {15'h0, a}, 16'h0);
        i2c_master_model_inst.stop();
        rd_cur(2, v);
        check("pointer after refusal", v, 16'h1900);
        i2c_master_model_inst.start();
        bx({4'h9, 3'h2, 1'b0}, 1'b1, q, a);
        check("foreign address", {15'h0, a}, 16'h0);
        i2c_master_model_inst.stop();
        @(negedge clk);
        strap = 3'h2;
        i2c_master_model_inst.start();
        bx({4'h9, 3'h2, 1'b0}, 1'b1, q, a);
        check("strap address", {15'h0, a}, 16'h1);
        i2c_master_model_inst.stop();
        @(negedge clk);
        strap = 3'h5;
        wr(2'h3, 16'h5000, 2);
        wr(2'h2, 16'h4B00, 2);
    endtask

    task automatic t_comp();
        logic [15:0] v;
        wait_oe(1'b0, 0, C + 10, "comparator idle");
        code(9'h0A0);
        hold_oe(1'b0, 2 * C, "equal is not over");
        code(9'h0A1);
        wait_oe(1'b1, 0, C + 10, "comparator trip");
        code(9'h098);
        hold_oe(1'b1, 2 * C, "above hysteresis");
        rd_cur(2, v);
        check("read keeps alarm", {15'h0, alarm_oe}, 16'h1);
        code(9'h095);
        wait_oe(1'b0, 0, C + 10, "comparator release");
    endtask

    task automatic t_queue();
        int n;
        for (int k = 0; k < 4; k++) begin
            n = (k == 3) ? 6 : 1 << k;
            wr(2'h1, {8'h00, 3'h0, 2'(k), 3'h0}, 1);
            code(9'h0A1);
            wait_oe(1'b1, (n - 1) * C, n * C + 10, "fault queue depth");
            code(9'h095);
            wait_oe(1'b0, 0, C + 10, "queue release");
        end
    endtask

    task automatic t_pol();
        wr(2'h1, 16'h0004, 1);
        wait_oe(1'b1, 0, 10, "inactive high level");
        code(9'h0A1);
        wait_oe(1'b0, 0, C + 10, "active high");
        code(9'h095);
        wait_oe(1'b1, 0, C + 10, "inactive again");
        check("alarm pin level", {15'h0, alarm_out}, 16'h0);
        check("data pin level", {15'h0, sda_out}, 16'h0);
    endtask

    // six-deep queue keeps a re-arm from landing inside the clearing read
    task automatic t_int();
        logic [15:0] v;
        wr(2'h1, 16'h001A, 1);
        code(9'h0A1);
        wait_oe(1'b1, 5 * C, 6 * C + 10, "interrupt trip");
        code(9'h095);
        hold_oe(1'b1, 7 * C, "held until read");
        rd_cur(1, v);
        check("read clears", {15'h0, alarm_oe}, 16'h0);
        wait_oe(1'b1, 4 * C, 6 * C + 10, "re-arm below");
        rd_cur(1, v);
        check("config readback", v, 16'h001A);
        check("second clear", {15'h0, alarm_oe}, 16'h0);
        code(9'h0A1);
        wait_oe(1'b1, 5 * C, 6 * C + 10, "interrupt again");
        wr(2'h1, 16'h001B, 1);
        check("shutdown clears", {15'h0, alarm_oe}, 16'h0);
        // the conversion in flight still lands before the halt
        repeat (C + 10) @(negedge clk);
        code(9'h0FA);
        repeat (C + 10) @(negedge clk);
        rdchk(2'h0, 2, 16'h5080, "result frozen");
    endtask

    task automatic stop_test();
        $display("compared %0d mismatches %0d", n_compared, fails);
        if (fails == 0 && n_compared > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    initial begin
        repeat (2) @(posedge clk);
        @(negedge clk);
        rst_n = 1'b1;
        repeat (3) @(negedge clk);
        t_reset();
        t_format();
        t_regs();
        t_comp();
        t_queue();
        t_pol();
        t_int();
        stop_test();
    end

    // the run needs about half this span
    initial begin
        #500000;
        fails++;
        stop_test();
    end
endmodule
